// ---- rtl/ivp_map.svh ----
// Offsets, reset values and constants of the interrupt vector and priority map.
`ifndef IVP_MAP_SVH
`define IVP_MAP_SVH
`define IVP_NUM_LINES 24
`define IVP_NUM_LVLREGS 6
`define IVP_VEC_BASE 16'hfffa
`define IVP_LVL_RESET 8'hff
`define IVP_OFF_LVL0 12'h000
`define IVP_OFF_LVL5 12'h014
`define IVP_OFF_STATUS 12'h020
`define IVP_OFF_MASK 12'h024
`define IVP_OFF_CPULVL 12'h028
`define IVP_OFF_WINNER 12'h02c
`define IVP_OFF_IRQ_STAT 12'h030
`define IVP_OFF_IRQ_MASK 12'h034
`define IVP_UNMAPPED_DATA 32'hdead_0000
`define IVP_EVT_ACCEPT 0
`define IVP_EVT_NEWREQ 1
`endif

// ---- rtl/ivp_pkg.sv ----
// Types shared by the interrupt vector and priority map.
package ivp_pkg;
    typedef struct packed {
        logic valid;
        logic [4:0] line;
        logic [1:0] level;
        logic [15:0] vector;
    } ivp_req_t;
    typedef struct packed {
        logic [1:0] ext_lo;
        logic [3:0] ext_hi;
        logic tmr0_lo;
        logic tmr0_hi;
        logic ser_rx;
        logic ser_tx;
        logic tmr1_hi;
        logic adc;
        logic tbt;
        logic wpre;
        logic tmr1_lo;
        logic flash;
    } ivp_src_t;
    typedef enum logic [2:0] {
        IVP_IDLE = 3'b001,
        IVP_PRESENT = 3'b010,
        IVP_ACK = 3'b100
    } ivp_state_t;
endpackage

// ---- rtl/ivp_level_regs.sv ----
// Bank of level registers holding the two-bit level field of every request line.
`timescale 1ns/100ps
`include "ivp_map.svh"
module ivp_level_regs #(
    parameter int NREG = `IVP_NUM_LVLREGS
) (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Write port.
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [7:0] wr_data,
    // Read port.
    input wire logic [2:0] rd_idx,
    output logic [7:0] rd_data_r,
    // All fields, flat.
    output logic [NREG*8-1:0] fields
);
    logic [7:0] mem_r [NREG];

    // Registers start at all ones, the least urgent level.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NREG; i++) begin
                mem_r[i] <= `IVP_LVL_RESET;
            end
        end else if (wr_en && (32'(wr_idx) < NREG)) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    // Registered read port.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_data_r <= 8'h00;
        end else if (32'(rd_idx) < NREG) begin
            rd_data_r <= mem_r[rd_idx];
        end else begin
            rd_data_r <= 8'h00;
        end
    end

    // Flatten for the arbiter.
    always_comb begin
        for (int i = 0; i < NREG; i++) begin
            fields[i*8 +: 8] = mem_r[i];
        end
    end
endmodule

// ---- rtl/ivp_top.sv ----
// Interrupt vector and priority map with APB register access.
`timescale 1ns/100ps
`include "ivp_map.svh"
module ivp_top #(
    parameter int NLINES = `IVP_NUM_LINES
) (
    // APB slave.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral request inputs.
    input wire ivp_pkg::ivp_src_t src,
    // CPU side.
    input wire logic [1:0] cpu_level,
    input wire logic cpu_ack,
    output ivp_pkg::ivp_req_t cpu_req,
    output logic cpu_take,
    // Interrupt output.
    output logic irq
);
    logic [NLINES-1:0] line_req;
    logic [NLINES-1:0] pend_r;
    logic [NLINES-1:0] mask_r;
    logic [47:0] lvl_fields;
    logic [7:0] lvl_rd;
    logic [1:0] cpu_lvl_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [1:0] evt;
    ivp_pkg::ivp_req_t win;
    ivp_pkg::ivp_req_t req_r;
    ivp_pkg::ivp_state_t state_r;
    ivp_pkg::ivp_state_t state_nxt;
    logic wr_acc;
    logic rd_setup;
    logic lvl_hit;
    logic [2:0] lvl_idx;
    logic rd_lvl_r;
    logic [31:0] rd_other_r;
    logic [7:0] lvl_hold_r;
    logic lvl_live;
    logic accept;

    // Vector address of a line.
    function automatic logic [15:0] vec_of(input logic [4:0] n);
        vec_of = 16'(`IVP_VEC_BASE - {10'h000, n, 1'b0});
    endfunction

    // Level field of a line out of the flat register bank.
    function automatic logic [1:0] lvl_of(input logic [47:0] f, input logic [4:0] n);
        lvl_of = f[{n, 1'b0} +: 2];
    endfunction

    // Source wiring onto request lines; unlisted lines stay low.
    always_comb begin
        line_req = '0;
        line_req[0] = src.ext_lo[0];
        line_req[1] = src.ext_lo[1];
        line_req[2] = src.ext_hi[0] | src.ext_hi[2];
        line_req[3] = src.ext_hi[1] | src.ext_hi[3];
        line_req[5] = src.tmr0_lo;
        line_req[6] = src.tmr0_hi;
        line_req[7] = src.ser_rx;
        line_req[8] = src.ser_tx;
        line_req[14] = src.tmr1_hi;
        line_req[18] = src.adc;
        line_req[19] = src.tbt;
        line_req[20] = src.wpre;
        line_req[22] = src.tmr1_lo;
        line_req[23] = src.flash;
    end

    // APB decode; the slave answers with no wait states.
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_acc = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign lvl_hit = (paddr <= `IVP_OFF_LVL5) && (paddr[1:0] == 2'b00);
    assign lvl_idx = paddr[4:2];

    ivp_level_regs #(
        .NREG(`IVP_NUM_LVLREGS)
    ) u_lvl (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(wr_acc & lvl_hit),
        .wr_idx(lvl_idx),
        .wr_data(pwdata[7:0]),
        .rd_idx(lvl_idx),
        .rd_data_r(lvl_rd),
        .fields(lvl_fields)
    );

    // The CPU accepts the presented line at this edge.
    assign accept = cpu_ack & cpu_take;

    // Pending bits follow the request lines, held until the CPU accepts them.
    // The bit is cleared at the accept edge, while the presented line is still known.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r <= '0;
        end else begin
            pend_r <= line_req | (pend_r & ~(accept ?
                      ({{(NLINES-1){1'b0}}, 1'b1} << req_r.line) : '0));
        end
    end

    // Winner: most urgent level (lowest value), ties to the lowest line.
    always_comb begin
        win = '0;
        win.level = 2'b11;
        for (int i = NLINES - 1; i >= 0; i--) begin
            if (pend_r[i] && !mask_r[i] &&
                (!win.valid || lvl_of(lvl_fields, 5'(i)) <= win.level)) begin
                win.valid = 1'b1;
                win.line = 5'(i);
                win.level = lvl_of(lvl_fields, 5'(i));
                win.vector = vec_of(5'(i));
            end
        end
    end

    // Presentation state machine.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ivp_pkg::IVP_IDLE: begin
                if (win.valid) begin
                    state_nxt = ivp_pkg::IVP_PRESENT;
                end
            end
            ivp_pkg::IVP_PRESENT: begin
                if (cpu_ack && cpu_take) begin
                    state_nxt = ivp_pkg::IVP_ACK;
                end else if (!win.valid) begin
                    state_nxt = ivp_pkg::IVP_IDLE;
                end
            end
            ivp_pkg::IVP_ACK: begin
                state_nxt = ivp_pkg::IVP_IDLE;
            end
            default: begin
                state_nxt = ivp_pkg::IVP_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ivp_pkg::IVP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Registered request toward the CPU, refreshed while not acknowledged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_r <= '0;
        end else if (state_nxt == ivp_pkg::IVP_PRESENT) begin
            req_r <= win;
        end else begin
            req_r <= '0;
        end
    end

    // The CPU may take the request only when it is more urgent than its level.
    assign cpu_req = req_r;
    assign cpu_take = req_r.valid && (state_r == ivp_pkg::IVP_PRESENT) &&
                      (req_r.level < cpu_lvl_r);

    // Current CPU level snapshot.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_lvl_r <= 2'b11;
        end else begin
            cpu_lvl_r <= cpu_level;
        end
    end

    // Events: an accepted request and a newly presented request.
    assign evt[`IVP_EVT_ACCEPT] = (state_r == ivp_pkg::IVP_ACK);
    assign evt[`IVP_EVT_NEWREQ] = (state_r == ivp_pkg::IVP_IDLE) && win.valid;

    // Line mask register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= '0;
        end else if (wr_acc && paddr == `IVP_OFF_MASK) begin
            mask_r <= pwdata[NLINES-1:0];
        end
    end

    // Sticky event status, write one to clear; a new event beats the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 2'b00;
        end else if (wr_acc && paddr == `IVP_OFF_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~pwdata[1:0]) | evt;
        end else begin
            irq_stat_r <= irq_stat_r | evt;
        end
    end

    // Event mask register; a one enables the event onto irq.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_r <= 2'b00;
        end else if (wr_acc && paddr == `IVP_OFF_IRQ_MASK) begin
            irq_mask_r <= pwdata[1:0];
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // Read data captured in the setup phase, returned in the access phase.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_lvl_r <= 1'b0;
            rd_other_r <= 32'h0000_0000;
        end else if (rd_setup) begin
            rd_lvl_r <= lvl_hit;
            case (paddr)
                `IVP_OFF_STATUS: rd_other_r <= {8'h00, pend_r};
                `IVP_OFF_MASK: rd_other_r <= {8'h00, mask_r};
                `IVP_OFF_CPULVL: rd_other_r <= {30'h0, cpu_lvl_r};
                `IVP_OFF_WINNER: rd_other_r <= {8'h00, req_r};
                `IVP_OFF_IRQ_STAT: rd_other_r <= {30'h0, irq_stat_r};
                `IVP_OFF_IRQ_MASK: rd_other_r <= {30'h0, irq_mask_r};
                default: rd_other_r <= `IVP_UNMAPPED_DATA;
            endcase
        end
    end

    // Level read data is held after the access so prdata stands until the next read.
    assign lvl_live = psel & penable & ~pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_hold_r <= 8'h00;
        end else if (lvl_live && rd_lvl_r) begin
            lvl_hold_r <= lvl_rd;
        end
    end

    // Writes to unimplemented offsets fall through with no effect.
    assign prdata = rd_lvl_r ? {24'h000000, (lvl_live ? lvl_rd : lvl_hold_r)} : rd_other_r;
endmodule

// ---- testbench/ivp_top_chk.sv ----
// Checker on the ports of the interrupt vector and priority map.
`timescale 1ns/100ps
`include "ivp_map.svh"
module ivp_chk #(
    parameter int NLINES = 24
) (
    // APB side.
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Sources and CPU side.
    input wire ivp_pkg::ivp_src_t src,
    input wire logic [1:0] cpu_level,
    input wire logic cpu_ack,
    input wire ivp_pkg::ivp_req_t cpu_req,
    input wire logic cpu_take,
    input wire logic irq
);
    // Lines that own a source; the others stay silent.
    localparam logic [23:0] USED = 24'hdc41ef;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Presented requests, acceptance and bus answers.
    chk_vec_addr: assert property (cpu_req.valid |->
        cpu_req.vector == 16'hfffa - {10'h0, cpu_req.line, 1'b0}) else $error("bad vector");
    chk_line_used: assert property (cpu_req.valid |-> USED[cpu_req.line])
        else $error("silent line presented");
    chk_take_lvl: assert property (cpu_take |->
        cpu_req.valid && cpu_req.level < $past(cpu_level)) else $error("take not urgent");
    chk_take_idle: assert property (!cpu_req.valid |-> !cpu_take)
        else $error("take without request");
    chk_accept_drop: assert property (cpu_ack && cpu_take |=> !cpu_req.valid && !cpu_take)
        else $error("request kept after accept");
    chk_bus_ok: assert property (pready && !pslverr)
        else $error("bus answer not normal");
    chk_rd_stable: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    chk_unmap_rd: assert property (psel && penable && !pwrite && paddr == 12'h040 |->
        prdata == `IVP_UNMAPPED_DATA) else $error("unmapped read value");
    // Main scenarios.
    cov_accept: cover property (cpu_ack && cpu_take);
    cov_last: cover property (cpu_req.valid && cpu_req.line == 5'h17);
    cov_unmap: cover property (psel && penable && paddr == 12'h040);
endmodule

// ---- testbench/ivp_cpu.sv ----
// Model of the CPU acceptance logic facing the map.
`timescale 1ns/100ps
module ivp_cpu (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Bench control: level to run at and accept delay.
    input wire logic [1:0] lvl,
    input wire logic [1:0] wait_n,
    // Map side.
    input wire logic cpu_take,
    output logic [1:0] cpu_level,
    output logic cpu_ack
);
    logic [1:0] cnt_r;
    // Accepts a takeable request after wait_n + 1 cycles of cpu_take, one pulse each.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 2'h0;
            cpu_ack <= 1'b0;
            cpu_level <= 2'h3;
        end else begin
            cpu_level <= lvl;
            if (cpu_take && !cpu_ack) begin
                cnt_r <= cnt_r + 2'h1;
                cpu_ack <= (cnt_r >= wait_n);
            end else begin
                cnt_r <= 2'h0;
                cpu_ack <= 1'b0;
            end
        end
    end
endmodule

// ---- testbench/test_irq_vector_priority_map.sv ----
// Testbench of the interrupt vector and priority map.
`timescale 1ns/100ps
module test_irq_vector_priority_map;
    localparam int NLINES = 24;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, cpu_ack, cpu_take, irq;
    logic [1:0] cpu_level, lvl = 2'h3, wait_n = 2'h0;
    logic [15:0] s;
    ivp_pkg::ivp_src_t src = '0;
    ivp_pkg::ivp_req_t cpu_req;
    logic [1:0] lv [24];
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    // Clock and run limit.
    always #2.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    ivp_top #(.NLINES(NLINES)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src(src), .cpu_level(cpu_level),
        .cpu_ack(cpu_ack), .cpu_req(cpu_req), .cpu_take(cpu_take), .irq(irq));
    ivp_cpu i_cpu (.pclk(pclk), .presetn(presetn), .lvl(lvl), .wait_n(wait_n),
        .cpu_take(cpu_take), .cpu_level(cpu_level), .cpu_ack(cpu_ack));
    // Line driven by each source bit, flash first.
    function automatic logic [4:0] ln(int i);
        logic [4:0] t [16] = '{5'h17, 5'h16, 5'h14, 5'h13, 5'h12, 5'h0e, 5'h08, 5'h07,
            5'h06, 5'h05, 5'h02, 5'h03, 5'h02, 5'h03, 5'h00, 5'h01};
        return t[i];
    endfunction
    // Expected winner: most urgent level, then lowest line.
    function automatic logic [4:0] win(logic [15:0] v);
        logic [4:0] b = 5'h00;
        logic [2:0] bl = 3'h4;
        for (int l = 0; l < 24; l++) begin
            for (int i = 0; i < 16; i++) begin
                if (v[i] && ln(i) == l && {1'b0, lv[l]} < bl) begin
                    b = 5'(l);
                    bl = {1'b0, lv[l]};
                end
            end
        end
        return b;
    endfunction
    task automatic cmp_w(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic cmp_b(string n, logic e, logic g);
        num_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s exp %b got %b", n, e, g);
        end
    endtask
    task automatic close_out();
        if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer; only mapped offsets are written.
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr_lv();
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, 12'(4 * k), {24'h0, lv[4*k+3], lv[4*k+2], lv[4*k+1], lv[4*k]});
        end
    endtask
    // Waits for an accept and checks what was presented.
    task automatic acc(logic [4:0] e, logic [1:0] el);
        int c = 0;
        do begin
            @(negedge pclk);
            c++;
        end while (!(cpu_ack === 1'b1 && cpu_take === 1'b1) && c < 80);
        cmp_b("accept", 1'b1, cpu_ack & cpu_take);
        cmp_w("line", {27'h0, e}, {27'h0, cpu_req.line});
        cmp_w("vector", {16'h0, 16'hfffa - 16'(2 * e)}, {16'h0, cpu_req.vector});
        cmp_w("level", {30'h0, el}, {30'h0, cpu_req.level});
        @(posedge pclk);
    endtask
    // Drops all sources, lets the CPU take what is left, clears events.
    task automatic drain();
        int c = 0;
        src <= '0;
        while (c < 8) begin
            @(posedge pclk);
            c = (cpu_req.valid !== 1'b0) ? 0 : c + 1;
        end
        apb(1'b1, 12'h030, 32'h3);
    endtask
    // Main sequence.
    initial begin
        void'($urandom(99174));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            cmp_w("lvl_rst", 32'hff, {24'h0, q[7:0]});
        end
        apb(1'b0, 12'h040, 32'h0);
        cmp_b("slverr", 1'b0, pslverr);
        apb(1'b1, 12'h024, 32'h0);
        apb(1'b1, 12'h034, 32'h1);
        lv = '{default: 2'h0};
        wr_lv();
        for (int i = 0; i < 16; i++) begin
            src <= ivp_pkg::ivp_src_t'(16'h1 << i);
            acc(ln(i), 2'h0);
            drain();
        end
        repeat (20) begin
            foreach (lv[l]) lv[l] = 2'($urandom % 3);
            wr_lv();
            apb(1'b0, 12'h00c, 32'h0);
            cmp_w("lvl_rw", {24'h0, lv[15], lv[14], lv[13], lv[12]}, {24'h0, q[7:0]});
            s = 16'($urandom) | 16'h1;
            wait_n <= 2'($urandom);
            src <= ivp_pkg::ivp_src_t'(s);
            acc(win(s), lv[win(s)]);
            drain();
        end
        wait_n <= 2'h0;
        lvl <= 2'h1;
        lv = '{default: 2'h1};
        wr_lv();
        src <= ivp_pkg::ivp_src_t'(16'h1);
        repeat (8) @(posedge pclk);
        cmp_b("take", 1'b0, cpu_take);
        cmp_b("valid", 1'b1, cpu_req.valid);
        lv[23] = 2'h0;
        wr_lv();
        acc(5'h17, 2'h0);
        src <= '0;
        repeat (8) @(posedge pclk);
        cmp_b("irq_set", 1'b1, irq);
        apb(1'b1, 12'h034, 32'h0);
        repeat (2) @(posedge pclk);
        cmp_b("irq_mask", 1'b0, irq);
        apb(1'b1, 12'h034, 32'h1);
        repeat (2) @(posedge pclk);
        cmp_b("irq_on", 1'b1, irq);
        apb(1'b1, 12'h030, 32'h1);
        repeat (2) @(posedge pclk);
        cmp_b("irq_clr", 1'b0, irq);
        close_out();
    end
endmodule
bind ivp_top ivp_chk #(.NLINES(NLINES)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src(src), .cpu_level(cpu_level),
    .cpu_ack(cpu_ack), .cpu_req(cpu_req), .cpu_take(cpu_take), .irq(irq));
